// ==== rtl/scg_gate_ctrl.sv ====
/*
  Sleep-mode clock gating register with APB slave, unit clock enables,
  gated-access fault detection and a fault interrupt.
  Assumes one 100 MHz clock, run and deep-sleep sets supplied from outside.
*/
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module scg_gate_ctrl (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Power mode and other gating sets
  input  wire logic [1:0]  power_mode,
  input  wire logic        auto_gating_enable,
  input  wire logic [31:0] run_clock_gate_1,
  input  wire logic [31:0] deep_sleep_clock_gate_1,
  // Unit side
  input  wire logic [31:0] unit_access,
  output logic      [31:0] unit_clk_en,
  output logic      [31:0] unit_fault,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] sleep_gate;
    logic [31:0] stat;
    logic [31:0] mask;
    logic [31:0] gate_en;
    logic [31:0] fault;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } scg_state_t;

  localparam scg_state_t STATE_RST = '{
    sleep_gate : scg_pkg::RST_SLEEP_CLOCK_GATE_1,
    stat       : scg_pkg::RST_FAULT_STATUS,
    mask       : scg_pkg::RST_FAULT_MASK,
    gate_en    : 32'h0000_0000,
    fault      : 32'h0000_0000,
    prdata     : 32'h0000_0000,
    pready     : 1'b0,
    pslverr    : 1'b0,
    irq        : 1'b0
  };

  scg_state_t  st_ff;
  scg_state_t  nxt_st;
  logic [31:0] gate_sel;
  logic        setup;
  logic        done;

  // Implemented bits rebuilt from the field positions, so the package mask is cross-checked
  localparam logic [31:0] IMPL_BITS = (32'h0000_0001 << scg_pkg::BIT_COMPARATOR_A_GATE)
                                    | (32'h0000_0001 << scg_pkg::BIT_TIMER_MODULE_C_GATE)
                                    | (32'h0000_0001 << scg_pkg::BIT_TIMER_MODULE_B_GATE)
                                    | (32'h0000_0001 << scg_pkg::BIT_TIMER_MODULE_A_GATE)
                                    | (32'h0000_0001 << scg_pkg::BIT_TWO_WIRE_PORT_GATE)
                                    | (32'h0000_0001 << scg_pkg::BIT_SYNC_SERIAL_PORT_GATE)
                                    | (32'h0000_0001 << scg_pkg::BIT_ASYNC_SERIAL_B_GATE)
                                    | (32'h0000_0001 << scg_pkg::BIT_ASYNC_SERIAL_A_GATE);

  // ----------------------------------------------------------------
  // Gating set selection
  // ----------------------------------------------------------------
  scg_gate_sel u_sel (
    .power_mode              (power_mode),
    .auto_gating_enable      (auto_gating_enable),
    .run_clock_gate_1        (run_clock_gate_1),
    .sleep_clock_gate_1      (st_ff.sleep_gate),
    .deep_sleep_clock_gate_1 (deep_sleep_clock_gate_1),
    .gate_sel                (gate_sel)
  );

  assign setup = psel && !penable;
  assign done  = psel && penable && st_ff.pready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.pready = setup;
    // Read data and error are fixed in the setup cycle, so the slave never waits
    if (setup) begin
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata  = 32'h0000_0000;
      unique case (paddr)
        scg_pkg::OFS_SLEEP_CLOCK_GATE_1: nxt_st.prdata = st_ff.sleep_gate;
        scg_pkg::OFS_FAULT_STATUS:       nxt_st.prdata = st_ff.stat;
        scg_pkg::OFS_FAULT_MASK:         nxt_st.prdata = st_ff.mask;
        scg_pkg::OFS_GATE_ACTIVE:        nxt_st.prdata = st_ff.gate_en;
        default:                         nxt_st.pslverr = 1'b1;
      endcase
    end
    if (done && pwrite && !st_ff.pslverr) begin
      if (paddr == scg_pkg::OFS_SLEEP_CLOCK_GATE_1) begin
        nxt_st.sleep_gate = pwdata & scg_pkg::GATE_IMPL_MASK;
      end
      if (paddr == scg_pkg::OFS_FAULT_MASK) begin
        nxt_st.mask = pwdata & scg_pkg::GATE_IMPL_MASK;
      end
    end
    // Clear only what was returned, so a fault landing mid-read is kept
    if (done && !pwrite && paddr == scg_pkg::OFS_FAULT_STATUS) begin
      nxt_st.stat = st_ff.stat & ~st_ff.prdata;
    end
    nxt_st.gate_en = gate_sel;
    nxt_st.fault   = unit_access & ~st_ff.gate_en & scg_pkg::GATE_IMPL_MASK;
    // Set wins over the read clear
    nxt_st.stat    = nxt_st.stat | nxt_st.fault;
    nxt_st.irq     = |(nxt_st.stat & nxt_st.mask);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata      = st_ff.prdata;
  assign pready      = st_ff.pready;
  assign pslverr     = st_ff.pslverr;
  assign unit_clk_en = st_ff.gate_en;
  assign unit_fault  = st_ff.fault;
  assign irq         = st_ff.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_RESET_CLEAR:
  assert property (@(posedge mclk) disable iff (rst)
    $past(rst) |-> (st_ff.sleep_gate == 32'h0000_0000 && unit_clk_en == 32'h0000_0000))
    else $error("Sleep gating not clear after reset");

  AST_RESERVED_ZERO:
  assert property (@(posedge mclk) disable iff (rst)
    ((st_ff.sleep_gate | unit_clk_en) & ~scg_pkg::GATE_IMPL_MASK) == 32'h0000_0000)
    else $error("Reserved gating bit set");

  AST_FIELD_WRITE:
  assert property (@(posedge mclk) disable iff (rst)
    (done && pwrite && !pslverr && paddr == scg_pkg::OFS_SLEEP_CLOCK_GATE_1)
      |=> st_ff.sleep_gate == ($past(pwdata) & IMPL_BITS))
    else $error("Sleep gating write not stored in documented bits");

  AST_SLEEP_SET:
  assert property (@(posedge mclk) disable iff (rst)
    (power_mode == scg_pkg::MODE_SLEEP && auto_gating_enable)
      |=> unit_clk_en == $past(st_ff.sleep_gate))
    else $error("Sleep set not applied in sleep mode");

  AST_DEEP_SET:
  assert property (@(posedge mclk) disable iff (rst)
    (power_mode == scg_pkg::MODE_DEEP_SLEEP && auto_gating_enable)
      |=> unit_clk_en == ($past(deep_sleep_clock_gate_1) & scg_pkg::GATE_IMPL_MASK))
    else $error("Deep-sleep set not applied");

  AST_NO_AUTO:
  assert property (@(posedge mclk) disable iff (rst)
    !auto_gating_enable
      |=> unit_clk_en == ($past(run_clock_gate_1) & scg_pkg::GATE_IMPL_MASK))
    else $error("Run set not applied without automatic gating");

  AST_GATED_FAULT:
  assert property (@(posedge mclk) disable iff (rst)
    1'b1 |=> unit_fault == ($past(unit_access) & ~$past(unit_clk_en)
                            & scg_pkg::GATE_IMPL_MASK))
    else $error("Fault does not match gated access");

  AST_FAULT_STICKY:
  assert property (@(posedge mclk) disable iff (rst)
    (unit_fault != 32'h0000_0000) |-> ((st_ff.stat & unit_fault) == unit_fault))
    else $error("Fault not recorded in status");

  AST_IRQ_LEVEL:
  assert property (@(posedge mclk) disable iff (rst)
    irq == |(st_ff.stat & st_ff.mask))
    else $error("Interrupt does not follow masked status");

  AST_ONE_WAIT:
  assert property (@(posedge mclk) disable iff (rst)
    (psel && !penable) |=> (pready ##1 !pready))
    else $error("APB answer not one cycle after setup");

  AST_SPARE_MODE_RUN:
  assert property (@(posedge mclk) disable iff (rst)
    (power_mode == 2'h3)
      |=> unit_clk_en == ($past(run_clock_gate_1) & scg_pkg::GATE_IMPL_MASK))
    else $error("Spare mode code did not fall back to the run set");

  AST_GATE_HOLD:
  assert property (@(posedge mclk) disable iff (rst)
    !(done && pwrite && paddr == scg_pkg::OFS_SLEEP_CLOCK_GATE_1)
      |=> $stable(st_ff.sleep_gate))
    else $error("Sleep gating changed without a write");

  AST_STATUS_CLEAR:
  assert property (@(posedge mclk) disable iff (rst)
    (done && !pwrite && paddr == scg_pkg::OFS_FAULT_STATUS)
      |=> st_ff.stat == (($past(st_ff.stat) & ~$past(prdata)) | unit_fault))
    else $error("Status read did not clear the returned bits");

  AST_ERR_NO_DATA:
  assert property (@(posedge mclk) disable iff (rst)
    (pready && pslverr) |-> prdata == 32'h0000_0000)
    else $error("Refused access returned data");

endmodule

// ==== rtl/scg_gate_sel.sv ====
/*
  Gating-set selector: picks run, sleep or deep-sleep enables by power mode.
  Assumes all inputs synchronous to one clock; purely combinational.
*/
`timescale 1ns/100ps
module scg_gate_sel (
  // Mode control
  input  wire logic [1:0]  power_mode,
  input  wire logic        auto_gating_enable,
  // Gating sets
  input  wire logic [31:0] run_clock_gate_1,
  input  wire logic [31:0] sleep_clock_gate_1,
  input  wire logic [31:0] deep_sleep_clock_gate_1,
  // Selected set
  output logic      [31:0] gate_sel
);

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // Without automatic gating the run set holds in every mode
  always_comb begin
    gate_sel = run_clock_gate_1;
    if (auto_gating_enable) begin
      if (power_mode == scg_pkg::MODE_SLEEP) begin
        gate_sel = sleep_clock_gate_1;
      end else if (power_mode == scg_pkg::MODE_DEEP_SLEEP) begin
        gate_sel = deep_sleep_clock_gate_1;
      end
    end
    gate_sel = gate_sel & scg_pkg::GATE_IMPL_MASK;
  end

endmodule

// ==== rtl/scg_pkg.sv ====
/*
  Package for the sleep-mode clock gating block: register offsets, field
  positions, reset values and power-mode codes.
  Assumes a 32-bit APB register bus with 12-bit byte addresses.
*/
package scg_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_SLEEP_CLOCK_GATE_1 = 12'h114;
  localparam logic [11:0] OFS_FAULT_STATUS       = 12'h118;
  localparam logic [11:0] OFS_FAULT_MASK         = 12'h11c;
  localparam logic [11:0] OFS_GATE_ACTIVE        = 12'h120;

  // ----------------------------------------------------------------
  // Field positions of the gating layout
  // ----------------------------------------------------------------
  localparam int BIT_COMPARATOR_A_GATE    = 24;
  localparam int BIT_TIMER_MODULE_C_GATE  = 18;
  localparam int BIT_TIMER_MODULE_B_GATE  = 17;
  localparam int BIT_TIMER_MODULE_A_GATE  = 16;
  localparam int BIT_TWO_WIRE_PORT_GATE   = 12;
  localparam int BIT_SYNC_SERIAL_PORT_GATE = 4;
  localparam int BIT_ASYNC_SERIAL_B_GATE  = 1;
  localparam int BIT_ASYNC_SERIAL_A_GATE  = 0;

  // Implemented bits; every other position is reserved and reads zero
  localparam logic [31:0] GATE_IMPL_MASK = 32'h0107_1013;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_SLEEP_CLOCK_GATE_1 = 32'h0000_0000;
  localparam logic [31:0] RST_FAULT_STATUS       = 32'h0000_0000;
  localparam logic [31:0] RST_FAULT_MASK         = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Power-mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_RUN        = 2'h0;
  localparam logic [1:0] MODE_SLEEP      = 2'h1;
  localparam logic [1:0] MODE_DEEP_SLEEP = 2'h2;

endpackage

// ==== verif/tb_top.sv ====
/*
  Self-checking bench for the sleep-mode clock gating block: APB register
  access, gating-set selection, gated-access faults and the fault interrupt.
  Assumes the design's package is compiled first; one 100 MHz clock.
*/
`timescale 1ns/100ps
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, irq, auto_gating_enable;
  logic [11:0] paddr;
  logic [1:0]  power_mode;
  logic [31:0] pwdata, prdata, run_clock_gate_1, deep_sleep_clock_gate_1;
  logic [31:0] unit_access, unit_clk_en, unit_fault, seed, rd, rs, rm, ra, en, f;
  logic        er;
  int          failures, checks_done, cycles;

  scg_gate_ctrl DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_mode(power_mode), .auto_gating_enable(auto_gating_enable),
    .run_clock_gate_1(run_clock_gate_1), .deep_sleep_clock_gate_1(deep_sleep_clock_gate_1),
    .unit_access(unit_access), .unit_clk_en(unit_clk_en), .unit_fault(unit_fault), .irq(irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Sleep set applies only with automatic gating on; mode 3 behaves as run
  function automatic logic [31:0] exp_en(input logic [1:0] m, input logic ag,
                                         input logic [31:0] r, s, d);
    if (ag && m == scg_pkg::MODE_SLEEP) return s & scg_pkg::GATE_IMPL_MASK;
    if (ag && m == scg_pkg::MODE_DEEP_SLEEP) return d & scg_pkg::GATE_IMPL_MASK;
    return r & scg_pkg::GATE_IMPL_MASK;
  endfunction

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask

  // One APB transfer; a clock edge passes first so psel is never set twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Whole run needs well under 1000 cycles; a stuck handshake ends here
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h0000_8e92;
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; power_mode = scg_pkg::MODE_RUN;
    auto_gating_enable = 1'b0; unit_access = 32'h0000_0000;
    run_clock_gate_1 = 32'h0000_0000; deep_sleep_clock_gate_1 = 32'h0000_0000;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, scg_pkg::OFS_SLEEP_CLOCK_GATE_1, 32'h0000_0000);
    chk32(rd, scg_pkg::RST_SLEEP_CLOCK_GATE_1);
    chk1(er, 1'b0);
    apb(1'b0, scg_pkg::OFS_FAULT_MASK, 32'h0000_0000);
    chk32(rd, scg_pkg::RST_FAULT_MASK);
    apb(1'b1, 12'h200, 32'hffff_ffff);
    chk1(er, 1'b1);
    apb(1'b0, 12'h200, 32'h0000_0000);
    chk32({rd[30:0], er}, 32'h0000_0001);
    $display("Test reset and unmapped done");
    // Every mode code with auto gating off then on; first pass writes all ones
    for (int i = 0; i < 8; i++) begin
      rs = (i == 0) ? 32'hffff_ffff : rnd();
      rm = rnd();
      apb(1'b1, scg_pkg::OFS_SLEEP_CLOCK_GATE_1, rs);
      apb(1'b1, scg_pkg::OFS_FAULT_MASK, rm);
      apb(1'b0, scg_pkg::OFS_SLEEP_CLOCK_GATE_1, 32'h0000_0000);
      chk32(rd, rs & scg_pkg::GATE_IMPL_MASK);
      power_mode <= i[1:0];
      auto_gating_enable <= i[2];
      run_clock_gate_1 <= rnd();
      deep_sleep_clock_gate_1 <= rnd();
      repeat (2) @(posedge mclk);
      en = exp_en(i[1:0], i[2], run_clock_gate_1, rs, deep_sleep_clock_gate_1);
      @(negedge mclk);
      chk32(unit_clk_en, en);
      ra = (i == 0) ? 32'hffff_ffff : rnd();
      f = ra & ~en & scg_pkg::GATE_IMPL_MASK;
      @(posedge mclk);
      unit_access <= ra;
      @(posedge mclk);
      unit_access <= 32'h0000_0000;
      @(negedge mclk);
      chk32(unit_fault, f);
      chk1(irq, |(f & rm & scg_pkg::GATE_IMPL_MASK));
      @(negedge mclk);
      chk32(unit_fault, 32'h0000_0000);
      apb(1'b0, scg_pkg::OFS_FAULT_STATUS, 32'h0000_0000);
      chk32(rd, f);
      apb(1'b0, scg_pkg::OFS_GATE_ACTIVE, 32'h0000_0000);
      chk32(rd, en);
      @(negedge mclk);
      chk1(irq, 1'b0);
      $display("Test mode %0d auto %0d done", i[1:0], i[2]);
    end
    summarize();
  end
endmodule
